/* include/alu_pkg.sv */
// constants, opcode decoding and register map of the rotate / subtract alu slice
package alu_pkg;

  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_OPCODE = 8'h00;
  localparam logic [7:0] ADDR_DST = 8'h04;
  localparam logic [7:0] ADDR_SRC = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ****************************************************************
  // opcodes
  // ****************************************************************
  localparam logic [7:0] OP_ROTL_CY_R = 8'h10;
  localparam logic [7:0] OP_ROTL_CY_IR = 8'h11;
  localparam logic [7:0] OP_ROTR_R = 8'hE0;
  localparam logic [7:0] OP_ROTR_IR = 8'hE1;
  localparam logic [7:0] OP_ROTR_CY_R = 8'hC0;
  localparam logic [7:0] OP_ROTR_CY_IR = 8'hC1;
  localparam logic [7:0] OP_SUBB_WW = 8'h32;
  localparam logic [7:0] OP_SUBB_WI = 8'h33;
  localparam logic [7:0] OP_SUBB_REG = 8'h34;
  localparam logic [7:0] OP_SUBB_IND = 8'h35;
  localparam logic [7:0] OP_SUBB_IMM = 8'h36;
  localparam logic [7:0] OP_CY_ONE = 8'hDF;

  // ****************************************************************
  // flag byte layout, status bits, reset values, timing
  // ****************************************************************
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAG_MASK = 8'hFC;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_BAD = 1;
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;

  // true for any of the six rotate opcodes
  function automatic logic is_rot(input logic [7:0] op);
    return op == OP_ROTL_CY_R || op == OP_ROTL_CY_IR || op == OP_ROTR_R ||
           op == OP_ROTR_IR || op == OP_ROTR_CY_R || op == OP_ROTR_CY_IR;
  endfunction

  // true for any of the five subtract-with-borrow opcodes
  function automatic logic is_subb(input logic [7:0] op);
    return op >= OP_SUBB_WW && op <= OP_SUBB_IMM;
  endfunction

  function automatic logic op_legal(input logic [7:0] op);
    return is_rot(op) || is_subb(op) || op == OP_CY_ONE;
  endfunction

  // only the OP_SUBB_WW subtract is short among subtracts
  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    return (is_subb(op) && op != OP_SUBB_WW) ? CYC_LONG : CYC_SHORT;
  endfunction

endpackage

/* src/alu_slice_core.sv */
// combinational datapath: rotates, subtract with borrow and set carry
`timescale 1ns/100ps
module alu_slice_core (
  // operation and operands
  input wire logic [7:0] op,
  input wire logic [7:0] dst,
  input wire logic [7:0] src,
  input wire logic [7:0] flags_in,
  // outcome
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  logic cin;
  logic [8:0] sum9;
  logic [4:0] sum5;

  // subtraction as dst + ~src + ~c; carry out means no borrow
  always_comb begin
    cin = flags_in[alu_pkg::FLAG_C];
    sum9 = {1'b0, dst} + {1'b0, ~src} + {8'h00, ~cin};
    sum5 = {1'b0, dst[3:0]} + {1'b0, ~src[3:0]} + {4'h0, ~cin};
  end

  // per-opcode result and flags; unlisted opcodes leave all as is
  always_comb begin
    result = dst;
    flags_out = flags_in;
    case (op)
      alu_pkg::OP_ROTL_CY_R, alu_pkg::OP_ROTL_CY_IR: begin
        result = {dst[6:0], cin};
        flags_out[alu_pkg::FLAG_C] = dst[7];
      end
      alu_pkg::OP_ROTR_R, alu_pkg::OP_ROTR_IR: begin
        result = {dst[0], dst[7:1]};
        flags_out[alu_pkg::FLAG_C] = dst[0];
      end
      alu_pkg::OP_ROTR_CY_R, alu_pkg::OP_ROTR_CY_IR: begin
        result = {cin, dst[7:1]};
        flags_out[alu_pkg::FLAG_C] = dst[0];
      end
      alu_pkg::OP_SUBB_WW, alu_pkg::OP_SUBB_WI, alu_pkg::OP_SUBB_REG,
      alu_pkg::OP_SUBB_IND, alu_pkg::OP_SUBB_IMM: begin
        result = sum9[7:0];
        flags_out[alu_pkg::FLAG_C] = ~sum9[8];
        flags_out[alu_pkg::FLAG_V] = (dst[7] ^ src[7]) & ~(sum9[7] ^ src[7]);
        flags_out[alu_pkg::FLAG_D] = 1'b1;
        flags_out[alu_pkg::FLAG_H] = ~sum5[4];
      end
      alu_pkg::OP_CY_ONE: begin
        flags_out[alu_pkg::FLAG_C] = 1'b1;
      end
      default: begin
        result = dst;
      end
    endcase
    // zero and sign are common to rotates and subtracts
    if (alu_pkg::is_rot(op) || alu_pkg::is_subb(op)) begin
      flags_out[alu_pkg::FLAG_Z] = (result == 8'h00);
      flags_out[alu_pkg::FLAG_S] = result[7];
    end
    if (alu_pkg::is_rot(op)) begin
      flags_out[alu_pkg::FLAG_V] = result[7] ^ dst[7];
    end
  end

endmodule

/* src/rotate_subtract_carry_alu.sv */
// apb-controlled alu slice: rotate through carry, rotate right, subtract with borrow
`timescale 1ns/100ps
module rotate_subtract_carry_alu (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // alu state towards the core
  output logic [7:0] alu_result,
  output logic [7:0] alu_flags,
  output logic busy,
  output logic done
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic setup;
  logic mapped;
  logic refuse;
  logic wr_en;
  logic [31:0] rd_word;
  logic [7:0] op_q;
  logic [7:0] dst_q;
  logic [7:0] src_q;
  logic bad_op_q;
  logic [2:0] cnt_q;
  logic start;
  logic finish;
  logic [7:0] core_result;
  logic [7:0] core_flags;

  assign setup = psel & ~penable;
  assign mapped = paddr == alu_pkg::ADDR_OPCODE || paddr == alu_pkg::ADDR_DST ||
                  paddr == alu_pkg::ADDR_SRC || paddr == alu_pkg::ADDR_FLAGS ||
                  paddr == alu_pkg::ADDR_RESULT || paddr == alu_pkg::ADDR_STATUS;
  // operands are frozen while busy, so any write then is refused
  assign refuse = ~mapped | (pwrite & busy);
  // error was decided in setup; a refused access never writes
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  assign start = wr_en & (paddr == alu_pkg::ADDR_OPCODE) & alu_pkg::op_legal(pwdata[7:0]);
  assign finish = busy & (cnt_q == 3'h0);

  // read mux, narrow registers in the low bits
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      alu_pkg::ADDR_OPCODE: rd_word = {24'h00_0000, op_q};
      alu_pkg::ADDR_DST: rd_word = {24'h00_0000, dst_q};
      alu_pkg::ADDR_SRC: rd_word = {24'h00_0000, src_q};
      alu_pkg::ADDR_FLAGS: rd_word = {24'h00_0000, alu_flags};
      alu_pkg::ADDR_RESULT: rd_word = {24'h00_0000, alu_result};
      alu_pkg::ADDR_STATUS: rd_word = {30'h0000_0000, bad_op_q, busy};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // one wait-free access phase: ready and data come from the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & refuse;
      if (setup) begin
        prdata <= (~mapped | pwrite) ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // a setup cycle is always answered in the very next cycle, never stretched
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("ready missing after setup");

  // ready is a single-cycle answer, so a held access cannot be taken twice
  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held for more than one cycle");

  // no selection, no answer on the next cycle
  a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> !pready)
    else $error("ready without a selected transfer");

  // an error is only meaningful while ready qualifies it
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error shown without ready");

  // holes in the map answer with an error
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pslverr)
    else $error("unmapped access not refused");

  // operands are frozen while an op runs, so writes then must be refused
  a_busy_write_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pwrite && busy |=> pslverr)
    else $error("write while busy not refused");

  // writes return an all-zero word rather than stale read data
  a_write_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pwrite |=> prdata == 32'h0000_0000)
    else $error("write returned nonzero read data");

  // ****************************************************************
  // operand registers
  // ****************************************************************

  // opcode is stored even when illegal so software can read it back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= alu_pkg::BYTE_RST;
      dst_q <= alu_pkg::BYTE_RST;
      src_q <= alu_pkg::BYTE_RST;
    end else if (wr_en) begin
      if (paddr == alu_pkg::ADDR_OPCODE) begin
        op_q <= pwdata[7:0];
      end
      if (paddr == alu_pkg::ADDR_DST) begin
        dst_q <= pwdata[7:0];
      end
      if (paddr == alu_pkg::ADDR_SRC) begin
        src_q <= pwdata[7:0];
      end
    end
  end

  // sticky illegal-opcode flag, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_op_q <= 1'b0;
    end else if (wr_en && paddr == alu_pkg::ADDR_OPCODE && !alu_pkg::op_legal(pwdata[7:0])) begin
      bad_op_q <= 1'b1;
    end else if (wr_en && paddr == alu_pkg::ADDR_STATUS && pwdata[alu_pkg::STATUS_BAD]) begin
      bad_op_q <= 1'b0;
    end
  end

  // an illegal opcode is kept for read-back, flagged, and never starts the sequencer
  a_bad_op_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == alu_pkg::ADDR_OPCODE && !alu_pkg::op_legal(pwdata[7:0]) |=>
    bad_op_q && !busy)
    else $error("illegal opcode not flagged");

  // write one to clear; no opcode write can share the cycle, so the clear is seen
  a_bad_op_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == alu_pkg::ADDR_STATUS && pwdata[alu_pkg::STATUS_BAD] |=> !bad_op_q)
    else $error("illegal opcode flag not cleared");

  // ****************************************************************
  // sequencer and datapath
  // ****************************************************************

  // busy for exactly the instruction's cycle count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt_q <= 3'h0;
    end else if (start) begin
      busy <= 1'b1;
      cnt_q <= 3'(alu_pkg::op_cycles(pwdata[7:0]) - 3'h1);
    end else if (busy) begin
      busy <= ~finish;
      cnt_q <= finish ? 3'h0 : 3'(cnt_q - 3'h1);
    end
  end

  // a legal opcode write starts the count at the very next edge
  a_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> busy)
    else $error("legal opcode did not start");

  // the counter never exceeds the longest instruction
  a_cnt_range: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_q < alu_pkg::CYC_LONG)
    else $error("cycle counter out of range");

  // done marks the cycle right after busy drops, and only that one
  a_done_after_busy: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> done)
    else $error("done missing after busy");

  a_done_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> !done)
    else $error("done longer than one cycle");

  // source, destination and opcode must not move under a running op
  a_ops_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    busy |=> $stable(op_q) && $stable(dst_q) && $stable(src_q))
    else $error("operands changed while busy");

  // flags only move on finish while busy, so the carry-in stays put
  a_flags_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    busy && !finish |=> $stable(alu_flags))
    else $error("flags changed mid-operation");

  alu_slice_core u_core (
    .op(op_q),
    .dst(dst_q),
    .src(src_q),
    .flags_in(alu_flags),
    .result(core_result),
    .flags_out(core_flags)
  );

  // results land on the last busy cycle; software may preset flags when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu_result <= alu_pkg::BYTE_RST;
      alu_flags <= alu_pkg::FLAGS_RST;
      done <= 1'b0;
    end else begin
      done <= finish;
      if (finish) begin
        alu_result <= core_result;
        alu_flags <= core_flags;
      end else if (wr_en && paddr == alu_pkg::ADDR_FLAGS) begin
        alu_flags <= pwdata[7:0] & alu_pkg::FLAG_MASK;
      end
    end
  end

  // the result byte stands until the next operation finishes
  a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !finish |=> $stable(alu_result))
    else $error("result changed without a finish");

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [7:0] fl_prev_q;
  logic [8:0] sub_ref;

  // flags as they stood one cycle back: the carry-in of the op that just finished
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_prev_q <= alu_pkg::FLAGS_RST;
    end else begin
      fl_prev_q <= alu_flags;
    end
  end

  // plain subtract reference, kept apart from the adder trick of the datapath
  assign sub_ref = {1'b0, dst_q} - {1'b0, src_q} - {8'h00, fl_prev_q[alu_pkg::FLAG_C]};

  a_rotl_shift: assert property (@(posedge pclk) disable iff (!presetn)
    done && (op_q == alu_pkg::OP_ROTL_CY_R || op_q == alu_pkg::OP_ROTL_CY_IR) |->
    alu_result == {dst_q[6:0], fl_prev_q[alu_pkg::FLAG_C]} &&
    alu_flags[alu_pkg::FLAG_C] == dst_q[7])
    else $error("rotate left through carry wrong");

  a_rotr_shift: assert property (@(posedge pclk) disable iff (!presetn)
    done && (op_q == alu_pkg::OP_ROTR_R || op_q == alu_pkg::OP_ROTR_IR) |->
    alu_result == {dst_q[0], dst_q[7:1]} && alu_flags[alu_pkg::FLAG_C] == dst_q[0])
    else $error("plain rotate right wrong");

  a_rotr_cy_shift: assert property (@(posedge pclk) disable iff (!presetn)
    done && (op_q == alu_pkg::OP_ROTR_CY_R || op_q == alu_pkg::OP_ROTR_CY_IR) |->
    alu_result == {fl_prev_q[alu_pkg::FLAG_C], dst_q[7:1]} &&
    alu_flags[alu_pkg::FLAG_C] == dst_q[0])
    else $error("rotate right through carry wrong");

  a_rot_keep_dh: assert property (@(posedge pclk) disable iff (!presetn)
    done && alu_pkg::is_rot(op_q) |->
    alu_flags[alu_pkg::FLAG_D] == fl_prev_q[alu_pkg::FLAG_D] &&
    alu_flags[alu_pkg::FLAG_H] == fl_prev_q[alu_pkg::FLAG_H])
    else $error("rotate changed decimal or half flag");

  a_rot_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    done && alu_pkg::is_rot(op_q) |-> alu_flags[alu_pkg::FLAG_V] == (alu_result[7] ^ dst_q[7]))
    else $error("rotate overflow flag wrong");

  a_rot_zero_sign: assert property (@(posedge pclk) disable iff (!presetn)
    done && alu_pkg::is_rot(op_q) |-> alu_flags[alu_pkg::FLAG_Z] == (alu_result == 8'h00) &&
    alu_flags[alu_pkg::FLAG_S] == alu_result[7])
    else $error("rotate zero or sign flag wrong");

  a_subb_value: assert property (@(posedge pclk) disable iff (!presetn)
    done && alu_pkg::is_subb(op_q) |-> alu_result == sub_ref[7:0] && $stable(src_q))
    else $error("subtract result wrong");

  a_subb_short: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) && op_q == alu_pkg::OP_SUBB_WW |-> busy [*4] ##1 !busy)
    else $error("short subtract not four cycles");

  a_subb_long: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) && alu_pkg::is_subb(op_q) && op_q != alu_pkg::OP_SUBB_WW |->
    busy [*6] ##1 !busy)
    else $error("long subtract not six cycles");

  a_subb_borrow: assert property (@(posedge pclk) disable iff (!presetn)
    done && alu_pkg::is_subb(op_q) |-> alu_flags[alu_pkg::FLAG_C] == sub_ref[8])
    else $error("subtract borrow flag wrong");

  a_subb_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    done && alu_pkg::is_subb(op_q) |-> alu_flags[alu_pkg::FLAG_V] ==
    ((dst_q[7] != src_q[7]) && (alu_result[7] == src_q[7])))
    else $error("subtract overflow flag wrong");

  a_subb_sign_dec: assert property (@(posedge pclk) disable iff (!presetn)
    done && alu_pkg::is_subb(op_q) |-> alu_flags[alu_pkg::FLAG_D] &&
    alu_flags[alu_pkg::FLAG_S] == alu_result[7] &&
    alu_flags[alu_pkg::FLAG_Z] == (alu_result == 8'h00))
    else $error("subtract sign zero or decimal flag wrong");

  a_subb_half: assert property (@(posedge pclk) disable iff (!presetn)
    done && alu_pkg::is_subb(op_q) |-> alu_flags[alu_pkg::FLAG_H] ==
    ({1'b0, dst_q[3:0]} < {1'b0, src_q[3:0]} + {4'h0, fl_prev_q[alu_pkg::FLAG_C]}))
    else $error("subtract half flag wrong");

  a_cy_one_flags: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) && op_q == alu_pkg::OP_CY_ONE |->
    busy [*4] ##1 (done && alu_flags == (fl_prev_q | (8'h01 << alu_pkg::FLAG_C))))
    else $error("set carry wrong");

  a_rot_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy) && alu_pkg::is_rot(op_q) |-> busy [*4] ##1 (!busy && done))
    else $error("rotate not four cycles");

endmodule

/* tb/core_side_model.sv */
// far-side model: core register file that takes each finished alu outcome
`timescale 1ns/100ps
module core_side_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // alu outcome
  input wire logic [7:0] alu_result,
  input wire logic [7:0] alu_flags,
  input wire logic done,
  // captured state
  output logic [7:0] reg_byte_q,
  output logic [7:0] flag_byte_q,
  output logic [7:0] n_done_q
);
  // write-back only on the done pulse; a stretched pulse shows as extra counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_byte_q <= 8'h00;
      flag_byte_q <= 8'h00;
      n_done_q <= 8'h00;
    end else if (done) begin
      reg_byte_q <= alu_result;
      flag_byte_q <= alu_flags;
      n_done_q <= n_done_q + 8'h01;
    end
  end
endmodule

/* tb/rotate_subtract_carry_alu_test.sv */
// self-checking bench: apb sequences of alu operations with computed outcomes
`timescale 1ns/100ps
module rotate_subtract_carry_alu_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, done;
  logic [7:0] alu_result, alu_flags, reg_byte, flag_byte, n_done;
  logic [31:0] rd;
  logic er;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] t_op [12] = '{8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1,
                            8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'hDF};
  logic [7:0] t_d [12] = '{8'hAA, 8'h17, 8'h31, 8'h17, 8'h55, 8'h17,
                           8'h10, 8'h20, 8'h00, 8'h03, 8'h20, 8'h5A};
  logic [7:0] t_s [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h03, 8'h03, 8'h00, 8'h03, 8'h8A, 8'h00};
  logic [7:0] t_f [12] = '{8'h0C, 8'h80, 8'h00, 8'h8C, 8'h00, 8'h84,
                           8'h80, 8'h80, 8'h80, 8'h00, 8'h80, 8'h0C};

  always #2 pclk = ~pclk;

  rotate_subtract_carry_alu dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alu_result(alu_result), .alu_flags(alu_flags),
    .busy(busy), .done(done));
  core_side_model core (.pclk(pclk), .presetn(presetn), .alu_result(alu_result),
    .alu_flags(alu_flags), .done(done), .reg_byte_q(reg_byte), .flag_byte_q(flag_byte),
    .n_done_q(n_done));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; waits for pready without assuming a wait-state count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // independent reckoning of result byte and flag byte
  function automatic void ref_op(input logic [7:0] op, d, s, f,
                                 output logic [7:0] r, output logic [7:0] fo);
    logic [8:0] w;
    logic [4:0] n;
    logic c;
    c = f[7];
    fo = f & 8'hFC;
    r = d;
    case (op)
      alu_pkg::OP_ROTL_CY_R, alu_pkg::OP_ROTL_CY_IR: begin
        r = {d[6:0], c};
        fo[7] = d[7];
        fo[4] = r[7] ^ d[7];
      end
      alu_pkg::OP_ROTR_R, alu_pkg::OP_ROTR_IR: begin
        r = {d[0], d[7:1]};
        fo[7] = d[0];
        fo[4] = r[7] ^ d[7];
      end
      alu_pkg::OP_ROTR_CY_R, alu_pkg::OP_ROTR_CY_IR: begin
        r = {c, d[7:1]};
        fo[7] = d[0];
        fo[4] = r[7] ^ d[7];
      end
      alu_pkg::OP_CY_ONE: fo[7] = 1'b1;
      default: begin
        w = {1'b0, d} - {1'b0, s} - c;
        n = {1'b0, d[3:0]} - {1'b0, s[3:0]} - c;
        r = w[7:0];
        fo[7] = w[8];
        fo[4] = (d[7] != s[7]) && (r[7] == s[7]);
        fo[3] = 1'b1;
        fo[2] = n[4];
      end
    endcase
    if (op != alu_pkg::OP_CY_ONE) begin
      fo[6] = (r == 8'h00);
      fo[5] = r[7];
    end
  endfunction

  // load operands, start, optionally collide with a write, then judge the outcome
  task automatic run_op(input logic [7:0] op, d, s, f, input logic clash);
    logic [7:0] xr, xf;
    int nb;
    ref_op(op, d, s, f, xr, xf);
    apb(1'b1, alu_pkg::ADDR_DST, {24'h0, d}, rd, er);
    apb(1'b1, alu_pkg::ADDR_SRC, {24'h0, s}, rd, er);
    apb(1'b1, alu_pkg::ADDR_FLAGS, {24'h0, f}, rd, er);
    apb(1'b1, alu_pkg::ADDR_OPCODE, {24'h0, op}, rd, er);
    if (clash) begin
      apb(1'b1, alu_pkg::ADDR_DST, 32'h0000_00A5, rd, er);
      check("write while busy err", 32'h1, {31'h0, er});
    end
    nb = 0;
    while (done !== 1'b1) begin
      @(posedge pclk);
      if (busy === 1'b1) nb++;
    end
    check("done seen", 32'h1, {31'h0, done});
    if (!clash)
      check("busy cycles", (is_six(op) ? 6 : 4), nb);
    check("result", {24'h0, xr}, {24'h0, alu_result});
    check("flags", {24'h0, xf}, {24'h0, alu_flags});
    @(posedge pclk);
    check("done pulse", 32'h0, {31'h0, done});
    check("core byte", {24'h0, xr}, {24'h0, reg_byte});
    check("core flags", {24'h0, xf}, {24'h0, flag_byte});
  endtask

  function automatic bit is_six(input logic [7:0] op);
    return op >= 8'h33 && op <= 8'h36;
  endfunction

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("reset outputs", 32'h0, {13'h0, alu_result, alu_flags, busy, done, pready});
    apb(1'b1, alu_pkg::ADDR_FLAGS, 32'h0000_00FF, rd, er);
    apb(1'b0, alu_pkg::ADDR_FLAGS, 32'h0, rd, er);
    check("flags mask", {24'h0, alu_pkg::FLAG_MASK}, rd);
    apb(1'b0, 8'h18, 32'h0, rd, er);
    check("unmapped err", 32'h1, {31'h0, er});
    check("unmapped data", 32'h0, rd);
    apb(1'b1, alu_pkg::ADDR_OPCODE, 32'h0000_0020, rd, er);
    apb(1'b0, alu_pkg::ADDR_STATUS, 32'h0, rd, er);
    check("bad opcode status", 32'h2, rd);
    apb(1'b1, alu_pkg::ADDR_STATUS, 32'h2, rd, er);
    apb(1'b0, alu_pkg::ADDR_STATUS, 32'h0, rd, er);
    check("status cleared", 32'h0, rd);
    for (int i = 0; i < 12; i++)
      run_op(t_op[i], t_d[i], t_s[i], t_f[i], 1'b0);
    run_op(alu_pkg::OP_SUBB_REG, 8'h50, 8'h10, 8'h00, 1'b1);
    apb(1'b0, alu_pkg::ADDR_RESULT, 32'h0, rd, er);
    check("result reg", 32'h40, rd);
    check("done count", 32'h0000_000D, {24'h0, n_done});
    stop_test();
  end
endmodule
